// ---- src/pdm_device.sv ----
// power-down mode logic at the cpu boundary
`timescale 1ns/10ps
`include "pdm_defs.svh"
module pdm_device #(
  parameter int RELOCK_CYCLES = `RELOCK_CYCLES
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // link to the controller
  pdm_if.device LINK,
  // observed state
  output pdm_pkg::pd_state_t STATE
);
  import pdm_pkg::*;
  pd_state_t state_reg;
  logic [31:0] csr_reg;
  pd_mode_t mode_reg;
  logic wake_service_reg, wake_resume_reg, spin_reg, pcfail_reg;
  logic entry_done, relock_done;
  logic [5:0] field;
  logic entry_load;
  pd_state_t state_next;
  pd_mode_t mode_next;
  logic cpu_clk_en_reg;
  logic dma_clk_en_reg;
  logic pll_out_en_reg;
  logic pll_in_en_reg;
  logic io_freeze_reg;
  initial if (RELOCK_CYCLES < 1 || RELOCK_CYCLES > 65535) $error("bad relock count");
  assign field = LINK.csr_wdata[`PD_FIELD_HI:`PD_FIELD_LO];

  function automatic pd_mode_t decode(input logic [5:0] code);
    if (code == `PD_CODE_LS_EN || code == `PD_CODE_LS_ANY)
      decode = MODE_LIGHT;
    else if (code == `PD_CODE_OUT_STOP)
      decode = MODE_OUT_STOP;
    else if (code == `PD_CODE_IN_STOP)
      decode = MODE_IN_STOP;
    else
      decode = MODE_NONE;
  endfunction

  function automatic logic is_deep(input pd_state_t s);
    is_deep = (s == ST_OUT_STOP || s == ST_IN_STOP);
  endfunction

  // light sleep ends on an enabled interrupt, or on any one for the any-wake code
  function automatic logic wake_ok(input logic pend, input logic en, input logic [5:0] code);
    wake_ok = pend && (en || code == `PD_CODE_LS_ANY);
  endfunction

  // =========================================
  // control register, kept through the deep modes; light sleep clears its mode field on a pending interrupt
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      csr_reg <= `STAT_RESET_VAL;
    else if (LINK.csr_wr && state_reg == ST_RUN)
      csr_reg <= LINK.csr_wdata;
    else if (state_reg == ST_LIGHT && LINK.irq_pending)
      csr_reg[`PD_FIELD_HI:`PD_FIELD_LO] <= `PD_CODE_NONE;
  end

  assign entry_load = LINK.csr_wr && state_reg == ST_RUN && decode(field) != MODE_NONE
    && !LINK.emu_attached;
  // the loading edge is the first of the nine entry cycles
  pdm_delay #(.WIDTH(16)) u_entry (
    .clk(SYS_CLK),
    .rst(RST),
    .load(entry_load),
    .count({12'h000, `PD_ENTRY_CYCLES - 4'h1}),
    .done(entry_done)
  );
  pdm_delay #(.WIDTH(16)) u_relock (
    .clk(SYS_CLK),
    .rst(RST),
    .load(state_reg == ST_RELOCK && LINK.pll_locked && !relock_done && 1'b0),
    .count(RELOCK_CYCLES[15:0]),
    .done(relock_done)
  );

  // =========================================
  // mode sequencer, next state kept apart so the gates can be registered from it
  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    case (state_reg)
      ST_RUN:
        if (entry_load)
        begin
          state_next = ST_ARM;
          mode_next = decode(field);
        end
      ST_ARM:
        if (LINK.emu_attached)
          state_next = ST_RUN;
        else if (entry_done)
          case (mode_reg)
            MODE_LIGHT: state_next = ST_LIGHT;
            MODE_OUT_STOP: state_next = ST_OUT_STOP;
            MODE_IN_STOP: state_next = ST_IN_STOP;
            default: state_next = ST_RUN;
          endcase
      ST_LIGHT:
        if (wake_ok(LINK.irq_pending, LINK.irq_enabled, csr_reg[`PD_FIELD_HI:`PD_FIELD_LO]))
          state_next = ST_RUN;
      // no interrupt or emulation command leaves a deep mode
      ST_OUT_STOP, ST_IN_STOP:
        state_next = state_reg;
      // after reset, as after power-up, the cpu clock stays gated until the pll is locked
      ST_RELOCK:
        if (LINK.pll_locked)
          state_next = ST_RUN;
      default:
        state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_reg <= ST_RELOCK;
      mode_reg <= MODE_NONE;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
    end
  end

  // =========================================
  // wake reporting and emulation handling
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      wake_service_reg <= 1'b0;
      wake_resume_reg <= 1'b0;
    end
    else
    begin
      wake_service_reg <= 1'b0;
      wake_resume_reg <= 1'b0;
      if (state_reg == ST_LIGHT && wake_ok(LINK.irq_pending, LINK.irq_enabled,
          csr_reg[`PD_FIELD_HI:`PD_FIELD_LO]))
      begin
        if (LINK.irq_enabled && csr_reg[`CSR_GIE_BIT] && LINK.nmi_enable)
          wake_service_reg <= 1'b1;
        else
          wake_resume_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      spin_reg <= 1'b0;
      pcfail_reg <= 1'b0;
    end
    else
    begin
      spin_reg <= LINK.emu_cmd && is_deep(state_reg);
      pcfail_reg <= LINK.pc_write && is_deep(state_reg);
    end
  end

  // =========================================
  // clock gates and freeze, registered from the next state so that no decode
  // glitch reaches a gate while the timing stays that of the state itself
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      cpu_clk_en_reg <= 1'b0;
      dma_clk_en_reg <= 1'b1;
      pll_out_en_reg <= 1'b1;
      pll_in_en_reg <= 1'b1;
      io_freeze_reg <= 1'b0;
    end
    else
    begin
      // cpu clock gated outside run and arm; deep modes also stop the dma clock and pll output, input-stop the pll input
      cpu_clk_en_reg <= (state_next == ST_RUN || state_next == ST_ARM);
      dma_clk_en_reg <= !is_deep(state_next);
      pll_out_en_reg <= !is_deep(state_next);
      pll_in_en_reg <= (state_next != ST_IN_STOP);
      io_freeze_reg <= is_deep(state_next);
    end
  end

  assign LINK.cpu_clk_en = cpu_clk_en_reg;
  assign LINK.dma_clk_en = dma_clk_en_reg;
  assign LINK.pll_out_en = pll_out_en_reg;
  assign LINK.pll_in_en = pll_in_en_reg;
  assign LINK.io_freeze = io_freeze_reg;
  assign LINK.wake_service = wake_service_reg;
  assign LINK.wake_resume = wake_resume_reg;
  assign LINK.emu_spin = spin_reg;
  assign LINK.pc_write_fail = pcfail_reg;
  assign LINK.csr_rdata = csr_reg;
  assign STATE = state_reg;
endmodule // pdm_device

// ---- src/pdm_defs.svh ----
// constants for the power-down mode controller
// What this block does
// - mode select from control register bits 15..10
// - software writes whole select field at once
// - software writes zero to field top bit
// - mode takes effect within nine cycles
// - software pads with no-ops after write
// - code 001001 light sleep, enabled wake only
// - code 010001 light sleep, any interrupt wakes
// - non-enabled wake resumes at sleep point
// - enabled wake runs service routine first
// - service needs global and nonmaskable enables
// - light sleep gates cpu clock, irq logic runs
// - code 011010 stops pll output clock
// - code 011100 stops pll input clock
// - deep modes retain registers and ram
// - deep modes freeze functional outputs
// - only reset ends deep modes
// - input-stop wake waits for pll relock
// - attached emulator masks power-down modes
// - deep modes spin emulation, reject pc writes
// - system holds reset until pll stable; the device instead waits in ST_RELOCK, cpu clock gated, for pll_locked
// - deep modes also gate the dma clock
`ifndef PDM_DEFS_SVH
`define PDM_DEFS_SVH
`define PD_FIELD_HI 15
`define PD_FIELD_LO 10
`define PD_CODE_NONE 6'h00
`define PD_CODE_LS_EN 6'h09
`define PD_CODE_LS_ANY 6'h11
`define PD_CODE_OUT_STOP 6'h1A
`define PD_CODE_IN_STOP 6'h1C
`define PD_ENTRY_CYCLES 4'h9
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_CPU_CSR 4'h8
`define CSR_GIE_BIT 0
`define STAT_RESET_VAL 32'h0000_0000
`define RELOCK_TIME_US 75
`define CLK_MHZ 200
`define RELOCK_CYCLES (`RELOCK_TIME_US * `CLK_MHZ)
`endif

// ---- src/pdm_pkg.sv ----
// types shared by both ends of the power-down controller
package pdm_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_ARM = 3'b001,
    ST_LIGHT = 3'b010,
    ST_OUT_STOP = 3'b011,
    ST_IN_STOP = 3'b100,
    ST_RELOCK = 3'b101
  } pd_state_t;
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_LIGHT = 2'b01,
    MODE_OUT_STOP = 2'b10,
    MODE_IN_STOP = 2'b11
  } pd_mode_t;
endpackage

// ---- src/pdm_if.sv ----
// link between the cpu-side controller and the power-down logic
`timescale 1ns/10ps
interface pdm_if;
  logic csr_wr;
  logic [31:0] csr_wdata;
  logic [31:0] csr_rdata;
  logic irq_pending;
  logic irq_enabled;
  logic nmi_enable;
  logic emu_attached;
  logic emu_cmd;
  logic pc_write;
  logic cpu_clk_en;
  logic pll_out_en;
  logic pll_in_en;
  logic io_freeze;
  logic dma_clk_en;
  logic wake_service;
  logic wake_resume;
  logic emu_spin;
  logic pc_write_fail;
  logic pll_locked;
  modport device (
    input csr_wr, csr_wdata, irq_pending, irq_enabled, nmi_enable, emu_attached,
    input emu_cmd, pc_write, pll_locked,
    output csr_rdata, cpu_clk_en, pll_out_en, pll_in_en, io_freeze, dma_clk_en,
    output wake_service, wake_resume, emu_spin, pc_write_fail
  );
  modport host (
    output csr_wr, csr_wdata, irq_pending, irq_enabled, nmi_enable, emu_attached,
    output emu_cmd, pc_write, pll_locked,
    input csr_rdata, cpu_clk_en, pll_out_en, pll_in_en, io_freeze, dma_clk_en,
    input wake_service, wake_resume, emu_spin, pc_write_fail
  );
endinterface

// ---- src/pdm_delay.sv ----
// small down-counter that times mode entry; the relock instance is never loaded
`timescale 1ns/10ps
module pdm_delay #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);
  logic [WIDTH-1:0] cnt_reg;
  logic busy_reg;
  initial if (WIDTH < 4) $error("pdm_delay width too small");
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end
    else if (load)
    begin
      cnt_reg <= count;
      busy_reg <= 1'b1;
    end
    else if (busy_reg && cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
    else
      busy_reg <= 1'b0;
  end
  assign done = busy_reg && (cnt_reg == '0);
endmodule // pdm_delay

// ---- src/pdm_host.sv ----
// controller end: axi4-lite registers driving the power-down link
`timescale 1ns/10ps
`include "pdm_defs.svh"
module pdm_host (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // axi4-lite slave
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [3:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [3:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // system pins
  input wire logic IRQ_PENDING,
  input wire logic EMU_ATTACHED,
  input wire logic PLL_LOCKED,
  // link to the power-down logic
  pdm_if.host LINK
);
  import pdm_pkg::*;
  logic aw_hold, w_hold;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg, ctrl_reg;
  logic wr_reg;
  logic [1:0] irq_s, emu_s, lock_s;
  // =========================================
  // pin synchronisers
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      irq_s <= 2'h0;
      emu_s <= 2'h0;
      lock_s <= 2'h0;
    end
    else
    begin
      irq_s <= {irq_s[0], IRQ_PENDING};
      emu_s <= {emu_s[0], EMU_ATTACHED};
      lock_s <= {lock_s[0], PLL_LOCKED};
    end
  end
  // =========================================
  // write channel: address and data in either order
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= 2'h0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      ctrl_reg <= 32'h0;
      wr_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= 1'b0;
      AWREADY <= !aw_hold && !AWREADY && !BVALID;
      WREADY <= !w_hold && !WREADY && !BVALID;
      if (AWVALID && AWREADY)
      begin
        aw_hold <= 1'b1;
        awaddr_reg <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_hold <= 1'b1;
        wdata_reg <= WDATA;
      end
      if (aw_hold && w_hold && !BVALID)
      begin
        BVALID <= 1'b1;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        if (awaddr_reg == `REG_CTRL)
        begin
          ctrl_reg <= wdata_reg; // whole field in one write
          BRESP <= 2'h0;
        end
        else if (awaddr_reg == `REG_CPU_CSR)
        begin
          wr_reg <= 1'b1; // top field bit forced low
          BRESP <= 2'h0;
        end
        else
          BRESP <= 2'h2;
      end
      else if (BVALID && BREADY)
        BVALID <= 1'b0;
    end
  end
  // =========================================
  // read channel
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= 2'h0;
    end
    else
    begin
      ARREADY <= !ARREADY && !RVALID;
      if (ARVALID && ARREADY)
      begin
        RVALID <= 1'b1;
        RRESP <= 2'h0;
        if (ARADDR == `REG_CTRL)
          RDATA <= ctrl_reg;
        else if (ARADDR == `REG_STATUS)
          RDATA <= {22'h0, LINK.pc_write_fail, LINK.emu_spin, LINK.io_freeze,
                    LINK.pll_in_en, LINK.pll_out_en, LINK.dma_clk_en,
                    LINK.cpu_clk_en, lock_s[1], emu_s[1], irq_s[1]};
        else if (ARADDR == `REG_CPU_CSR)
          RDATA <= LINK.csr_rdata;
        else
        begin
          RDATA <= 32'h0;
          RRESP <= 2'h2;
        end
      end
      else if (RVALID && RREADY)
        RVALID <= 1'b0;
    end
  end
  // the recommended no-op padding is the bus gap after the write
  assign LINK.csr_wr = wr_reg;
  assign LINK.csr_wdata = {16'h0, 1'b0, wdata_reg[14:0]};
  assign LINK.irq_pending = irq_s[1];
  assign LINK.irq_enabled = ctrl_reg[0];
  assign LINK.nmi_enable = ctrl_reg[1];
  assign LINK.emu_attached = emu_s[1];
  assign LINK.emu_cmd = ctrl_reg[2];
  assign LINK.pc_write = ctrl_reg[3];
  assign LINK.pll_locked = lock_s[1];
endmodule // pdm_host

// ---- bench/pdm_sva.sv ----
// concurrent checks on the power-down link
`timescale 1ns/10ps
module pdm_sva (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // link signals
  input wire logic csr_wr,
  input wire logic [31:0] csr_wdata,
  input wire logic irq_enabled,
  input wire logic nmi_enable,
  input wire logic emu_attached,
  input wire logic emu_cmd,
  input wire logic pc_write,
  input wire logic pll_locked,
  input wire logic cpu_clk_en,
  input wire logic pll_out_en,
  input wire logic pll_in_en,
  input wire logic io_freeze,
  input wire logic dma_clk_en,
  input wire logic wake_service,
  input wire logic wake_resume,
  input wire logic emu_spin,
  input wire logic pc_write_fail
);
  // ==========
  // helper state
  logic [5:0] code;
  logic gie_reg;
  logic deep_reg;
  assign code = csr_wdata[15:10];
  always_ff @(posedge SYS_CLK)
    if (RST) gie_reg <= 1'b0;
    else if (csr_wr) gie_reg <= csr_wdata[0];
  // deep flag sticks until reset, so deep-only checks stay off in light sleep
  always_ff @(posedge SYS_CLK)
    if (RST) deep_reg <= 1'b0;
    else if (csr_wr && !emu_attached && code inside {6'h1A, 6'h1C}) deep_reg <= 1'b1;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // ==========
  // properties
  property p_light_entry;
    csr_wr && code inside {6'h09, 6'h11} && !emu_attached && cpu_clk_en
      |-> ##[1:11] !cpu_clk_en && dma_clk_en;
  endproperty
  a_light_entry: assert property (p_light_entry) else $error("light sleep late");
  property p_out_stop;
    csr_wr && code == 6'h1A && !emu_attached |-> ##[1:11] !pll_out_en && io_freeze;
  endproperty
  a_out_stop: assert property (p_out_stop) else $error("pll output not stopped");
  property p_in_stop;
    csr_wr && code == 6'h1C && !emu_attached |-> ##[1:11] !pll_in_en && io_freeze;
  endproperty
  a_in_stop: assert property (p_in_stop) else $error("pll input not stopped");
  property p_reserved;
    csr_wr && cpu_clk_en && !(code inside {6'h09, 6'h11, 6'h1A, 6'h1C}) |=> cpu_clk_en [*8];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code slept");
  property p_emu_mask;
    csr_wr && emu_attached && cpu_clk_en |=> cpu_clk_en [*8];
  endproperty
  a_emu_mask: assert property (p_emu_mask) else $error("sleep with emulator");
  property p_deep_hold;
    deep_reg && io_freeze |=> io_freeze && !cpu_clk_en;
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("deep mode left");
  property p_spin;
    deep_reg && io_freeze && emu_cmd && pc_write |-> ##[0:3] emu_spin && pc_write_fail;
  endproperty
  a_spin: assert property (p_spin) else $error("emulation not spinning");
  property p_service_gate;
    wake_service |-> irq_enabled && nmi_enable && gie_reg;
  endproperty
  a_service_gate: assert property (p_service_gate) else $error("service not gated");
  property p_wake_pulse;
    wake_service || wake_resume |=> !(wake_service || wake_resume) ##[0:2] cpu_clk_en;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake did not resume");
  property p_relock_wait;
    !pll_locked && !cpu_clk_en |=> !cpu_clk_en;
  endproperty
  a_relock_wait: assert property (p_relock_wait) else $error("ran before lock");
  c_service: cover property (wake_service);
  c_resume: cover property (wake_resume);
  c_spin: cover property (deep_reg && emu_spin);
endmodule // pdm_sva

// ---- bench/power_down_mode_control_tb.sv ----
// self-checking bench for the power-down controller pair
`timescale 1ns/10ps
module power_down_mode_control_tb;
  import pdm_pkg::*;
  // ==========
  // signals and instances
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic IRQ_PENDING = 1'b0, EMU_ATTACHED = 1'b0, PLL_LOCKED = 1'b1;
  logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0;
  logic [31:0] WDATA = 32'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP, resp;
  logic [31:0] RDATA, rd_data;
  logic [15:0] lfsr = 16'h0006;
  logic [5:0] code;
  pd_state_t STATE;
  int num_errors = 0, checks_done = 0, cycles = 0, n_svc = 0, n_res = 0;
  pdm_if u_pdm_if ();
  pdm_host u_pdm_host (.SYS_CLK(SYS_CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .BVALID(BVALID),
    .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP), .IRQ_PENDING(IRQ_PENDING),
    .EMU_ATTACHED(EMU_ATTACHED), .PLL_LOCKED(PLL_LOCKED), .LINK(u_pdm_if));
  pdm_device u_pdm_device (.SYS_CLK(SYS_CLK), .RST(RST), .LINK(u_pdm_if), .STATE(STATE));
  pdm_sva u_pdm_sva (.SYS_CLK(SYS_CLK), .RST(RST), .csr_wr(u_pdm_if.csr_wr),
    .csr_wdata(u_pdm_if.csr_wdata), .irq_enabled(u_pdm_if.irq_enabled),
    .nmi_enable(u_pdm_if.nmi_enable), .emu_attached(u_pdm_if.emu_attached),
    .emu_cmd(u_pdm_if.emu_cmd), .pc_write(u_pdm_if.pc_write), .pll_locked(u_pdm_if.pll_locked),
    .cpu_clk_en(u_pdm_if.cpu_clk_en), .pll_out_en(u_pdm_if.pll_out_en),
    .pll_in_en(u_pdm_if.pll_in_en), .io_freeze(u_pdm_if.io_freeze),
    .dma_clk_en(u_pdm_if.dma_clk_en), .wake_service(u_pdm_if.wake_service),
    .wake_resume(u_pdm_if.wake_resume), .emu_spin(u_pdm_if.emu_spin),
    .pc_write_fail(u_pdm_if.pc_write_fail));
  always #2.5 SYS_CLK = ~SYS_CLK;
  // wake pulses are counted here; the ceiling is far above the under 1000 cycles used
  always @(posedge SYS_CLK)
  begin
    n_svc += (u_pdm_if.wake_service === 1'b1);
    n_res += (u_pdm_if.wake_resume === 1'b1);
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test;
    end
  end
  // ==========
  // helpers
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] csr_word(input logic [5:0] c, input logic global_irq_enable);
    return {16'h0, c, 9'h0, global_irq_enable};
  endfunction
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge SYS_CLK);
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= d;
    BREADY <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge SYS_CLK);
      aw_done = aw_done || AWREADY === 1'b1;
      w_done = w_done || WREADY === 1'b1;
      AWVALID <= !aw_done;
      WVALID <= !w_done;
    end
    do @(posedge SYS_CLK); while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    resp = BRESP;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge SYS_CLK);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    do @(posedge SYS_CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    while (RVALID !== 1'b1) @(posedge SYS_CLK);
    RREADY <= 1'b0;
    rd_data = RDATA;
    resp = RRESP;
  endtask
  // n of zero gives a plain check of the present state
  task automatic wait_state(input pd_state_t s, input int n);
    for (int i = 0; i < n && STATE !== s; i++) @(posedge SYS_CLK);
    chk(32'(STATE), 32'(s));
  endtask
  task automatic do_reset;
    RST <= 1'b1;
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
  endtask
  task automatic light_case(input logic [5:0] c, input logic [3:0] ctrl, input logic global_irq_enable);
    logic svc;
    svc = ctrl[0] & ctrl[1] & global_irq_enable;
    axi_wr(4'h0, {28'h0, ctrl});
    axi_wr(4'h8, csr_word(c, global_irq_enable));
    wait_state(ST_LIGHT, 12);
    axi_rd(4'h4);
    chk(32'(rd_data[4:3]), 32'h2);
    IRQ_PENDING <= 1'b1;
    n_svc = 0;
    n_res = 0;
    if (c[4:0] != 5'h11 && !ctrl[0])
    begin
      repeat (20) @(posedge SYS_CLK);
      wait_state(ST_LIGHT, 0);
      axi_wr(4'h0, {28'h0, ctrl | 4'h1});
      svc = ctrl[1] & global_irq_enable;
    end
    wait_state(ST_RUN, 20);
    IRQ_PENDING <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    chk(32'(n_svc), 32'(svc));
    chk(32'(n_res), 32'(!svc));
  endtask
  task automatic deep_case(input logic [5:0] c, input pd_state_t s, input logic relock);
    axi_wr(4'h0, 32'h0);
    axi_wr(4'h8, csr_word(c, 1'b1));
    wait_state(s, 12);
    IRQ_PENDING <= 1'b1;
    axi_wr(4'h0, 32'hF);
    repeat (30) @(posedge SYS_CLK);
    wait_state(s, 0);
    axi_rd(4'h4);
    chk(32'(rd_data[9:7]), 32'h7);
    chk(32'(rd_data[relock ? 6 : 5]), 32'h0);
    chk(32'(rd_data[2:0]), 32'h5);
    axi_rd(4'h0);
    chk(rd_data, 32'h0000_000F);
    IRQ_PENDING <= 1'b0;
    PLL_LOCKED <= !relock;
    do_reset;
    repeat (40) @(posedge SYS_CLK);
    if (relock)
      wait_state(ST_RELOCK, 0);
    PLL_LOCKED <= 1'b1;
    wait_state(ST_RUN, 20);
  endtask
  // ==========
  // main sequence
  initial
  begin
    do_reset;
    wait_state(ST_RUN, 20);
    axi_rd(4'hC);
    chk({resp, rd_data[29:0]}, 32'h8000_0000);
    axi_rd(4'h4);
    chk(32'(rd_data[9:3]), 32'h0F);
    axi_wr(4'h8, 32'h0);
    chk(32'(resp), 32'h0);
    axi_wr(4'hC, 32'h0000_FC00);
    chk(32'(resp), 32'h2);
    wait_state(ST_RUN, 0);
    repeat (8)
    begin
      lfsr = next_rand(lfsr);
      code = lfsr[5:0];
      if (!(code[4:0] inside {5'h09, 5'h11, 5'h1A, 5'h1C}))
      begin
        axi_wr(4'h8, csr_word(code, lfsr[6]));
        repeat (12) @(posedge SYS_CLK);
        wait_state(ST_RUN, 0);
      end
    end
    light_case(6'h09, 4'h3, 1'b1);
    light_case(6'h09, 4'h1, 1'b1);
    light_case(6'h09, 4'h0, 1'b1);
    light_case(6'h11, 4'h0, 1'b0);
    light_case(6'h29, 4'h3, 1'b0);
    axi_rd(4'h8);
    chk(32'(rd_data[15]), 32'h0);
    EMU_ATTACHED <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    axi_wr(4'h8, csr_word(6'h1A, 1'b0));
    repeat (20) @(posedge SYS_CLK);
    wait_state(ST_RUN, 0);
    // clear the request so nothing stays pending once the cable is gone
    axi_wr(4'h8, 32'h0);
    EMU_ATTACHED <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    deep_case(6'h1A, ST_OUT_STOP, 1'b0);
    deep_case(6'h1C, ST_IN_STOP, 1'b1);
    stop_test;
  end
endmodule // power_down_mode_control_tb
